// ### mlc_chip_match.sv
// Chip type comparator for one option line
module mlc_chip_match #(
    parameter logic [9:0] CODE = 10'h000
) (
    input  wire logic [4:0] i_chip_hi,
    input  wire logic [4:0] i_chip_lo,
    output logic            o_match
);
    import mlc_pkg::*;

    assign o_match = (i_chip_lo == MLC_CHIP_UNIV) || ({i_chip_hi, i_chip_lo} == CODE);
endmodule

// ### mlc_loop_ctrl.sv
// Maintenance loop controller: APB command entry, loop fan-out, configuration and maintenance state
// Notes on behaviour
// - Broadcast loop value drives all 16/32 loops
// - Only option matching chip type accepts function
// - Chip type 33 accepted by every option
// - Chip fields are 5-bit letters, A=1
// - Chip bits 17..8, loop field up to 23
// - Route bits 24..28 steer into controller
// - Distribute 8-bit function code, 256 values
// - Defaults forced without sanity or on 77
// - I/O codes 10/11 set path, 12 clears
// - I/O codes 20..25 group and memory bits
// - I/O codes 26/27, 30/31 I/O group bits
// - Shared codes 40..43 choose position source
// - Shared codes 70/71 remote sanity enable
// - Shared codes 0/1 broadcast cluster detach
// - Shared 45 data enable, 44 maintenance default
// - Maintenance functions rejected until code 176
// - Code 177 or master clear ends maintenance
// - BSCAN code 61 disables logger, returns disconnect
module mlc_loop_ctrl #(
    parameter int NLOOP = mlc_pkg::MLC_NLOOP_IO,
    parameter int NOPT  = mlc_pkg::MLC_NOPT
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [7:0]            i_paddr,
    input  wire logic [31:0]           i_pwdata,
    output logic      [31:0]           o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    input  wire logic                  i_sanity_ok,
    input  wire logic                  i_cpu_mclr,
    output logic                       o_strobe,
    output logic      [NLOOP-1:0]      o_loop_sel,
    output logic      [7:0]            o_func,
    output logic      [NOPT-1:0]       o_opt_accept,
    output mlc_pkg::mlc_cfg_s          o_cfg,
    output logic                       o_maint_mode,
    output logic                       o_maint_func_act,
    output logic                       o_logger_en,
    output logic                       o_disconnect
);
    import mlc_pkg::*;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic        wr_go;
    logic        issue;
    logic        mapped;
    mlc_cmd_s    in_cmd;
    mlc_cmd_s    last_cmd;
    logic [31:0] cmd_hi;
    mlc_mod_e    mod_type;
    logic        disc_sticky;
    logic        clr_disc;
    logic [31:0] next_rdata;

    assign wr_go  = i_psel && i_penable && o_pready && i_pwrite;
    assign in_cmd = mlc_cmd_s'(i_pwdata[MLC_CMD_W-1:0]);
    assign issue  = wr_go && (i_paddr == MLC_OFF_CMD_LO);
    assign mapped = (i_paddr == MLC_OFF_CMD_LO) || (i_paddr == MLC_OFF_CMD_HI) ||
                    (i_paddr == MLC_OFF_CTRL) || (i_paddr == MLC_OFF_STAT) ||
                    (i_paddr == MLC_OFF_CFG);
    assign clr_disc = wr_go && (i_paddr == MLC_OFF_STAT) && i_pwdata[3];

    always_comb begin
        next_rdata = '0;
        unique case (i_paddr)
            MLC_OFF_CMD_LO: next_rdata[MLC_CMD_W-1:0] = last_cmd;
            MLC_OFF_CMD_HI: next_rdata = cmd_hi;
            MLC_OFF_CTRL:   next_rdata[1:0] = mod_type;
            MLC_OFF_STAT:   next_rdata[3:0] = {disc_sticky, o_logger_en, o_maint_func_act, o_maint_mode};
            MLC_OFF_CFG:    next_rdata[$bits(mlc_cfg_s)-1:0] = o_cfg;
            default:        next_rdata = '0;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= '0;
        end else begin
            o_pready  <= i_psel && i_penable && !o_pready;
            o_pslverr <= i_psel && i_penable && !o_pready && !mapped;
            if (i_psel && i_penable && !o_pready && !i_pwrite) begin
                o_prdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cmd_hi   <= '0;
            mod_type <= mlc_mod_e'(MLC_CTRL_RST);
            last_cmd <= '0;
        end else begin
            if (wr_go && i_paddr == MLC_OFF_CMD_HI) begin
                cmd_hi <= i_pwdata;
            end
            if (wr_go && i_paddr == MLC_OFF_CTRL) begin
                mod_type <= mlc_mod_e'(i_pwdata[1:0]);
            end
            if (issue) begin
                last_cmd <= in_cmd;
            end
        end
    end

    // ----------------------------------------------------------------
    // Command acceptance
    // ----------------------------------------------------------------
    logic route_ok;
    logic is_maint;
    logic deliver;

    assign route_ok = issue && (in_cmd.route == MLC_ROUTE_LC);
    assign is_maint = (in_cmd.func[7:6] == MLC_CLASS_MNT);
    assign deliver  = route_ok && (!is_maint || o_maint_mode ||
                      in_cmd.func == MLC_FC_MAINT_SET || in_cmd.func == MLC_FC_MAINT_CLR);

    // ----------------------------------------------------------------
    // Loop and option fan-out
    // ----------------------------------------------------------------
    logic [NLOOP-1:0] sel;
    logic [NOPT-1:0]  match;

    mlc_loop_decode #(
        .NLOOP_IO  (NLOOP),
        .NLOOP_STD (MLC_NLOOP_STD)
    ) u_loop_decode (
        .i_loop (in_cmd.loop),
        .i_io   (mod_type == MLC_MOD_IO),
        .o_sel  (sel)
    );

    for (genvar g = 0; g < NOPT; g++) begin : g_opt
        mlc_chip_match #(
            .CODE (MLC_OPT_CODE[g])
        ) u_chip_match (
            .i_chip_hi (in_cmd.chip_hi),
            .i_chip_lo (in_cmd.chip_lo),
            .o_match   (match[g])
        );
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_strobe     <= 1'b0;
            o_loop_sel   <= '0;
            o_func       <= '0;
            o_opt_accept <= '0;
        end else begin
            o_strobe     <= deliver;
            o_loop_sel   <= deliver ? sel : '0;
            o_opt_accept <= (deliver && |sel) ? match : '0;
            if (deliver) begin
                o_func <= in_cmd.func;
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration state
    // ----------------------------------------------------------------
    mlc_cfg_s next_cfg;

    always_comb begin
        next_cfg = o_cfg;
        if (route_ok && mod_type == MLC_MOD_IO) begin
            unique case (in_cmd.func)
                MLC_FC_PATH0_SET:   next_cfg.io_path[0] = 1'b1;
                MLC_FC_PATH1_SET:   next_cfg.io_path[1] = 1'b1;
                MLC_FC_PATH_CLR:    next_cfg.io_path = 2'h0;
                MLC_FC_GRPMODE_SET: next_cfg.io_group_mode = 1'b1;
                MLC_FC_GRPMODE_CLR: next_cfg.io_group_mode = 1'b0;
                MLC_FC_MEMG0_SET:   next_cfg.io_mem_grp[0] = 1'b1;
                MLC_FC_MEMG0_CLR:   next_cfg.io_mem_grp[0] = 1'b0;
                MLC_FC_MEMG1_SET:   next_cfg.io_mem_grp[1] = 1'b1;
                MLC_FC_MEMG1_CLR:   next_cfg.io_mem_grp[1] = 1'b0;
                MLC_FC_IOG0_SET:    next_cfg.io_io_grp[0] = 1'b1;
                MLC_FC_IOG0_CLR:    next_cfg.io_io_grp[0] = 1'b0;
                MLC_FC_IOG1_SET:    next_cfg.io_io_grp[1] = 1'b1;
                MLC_FC_IOG1_CLR:    next_cfg.io_io_grp[1] = 1'b0;
                default:            next_cfg = o_cfg;
            endcase
        end else if (route_ok && mod_type == MLC_MOD_SHARED) begin
            if (in_cmd.func >= MLC_FC_POS_HW && in_cmd.func <= MLC_FC_POS_F1) begin
                next_cfg.sr_pos = in_cmd.func[1:0];
            end
            unique case (in_cmd.func)
                MLC_FC_DETACH_ON:  next_cfg.sr_auto_detach = 1'b1;
                MLC_FC_DETACH_OFF: next_cfg.sr_auto_detach = 1'b0;
                MLC_FC_MAINT100:   next_cfg.sr_data_en = 1'b0;
                MLC_FC_DATA_EN:    next_cfg.sr_data_en = 1'b1;
                MLC_FC_RSAN_ON:    next_cfg.sr_remote_sanity = 1'b1;
                MLC_FC_RSAN_OFF:   next_cfg.sr_remote_sanity = 1'b0;
                default:           ;
            endcase
        end
        if (!i_sanity_ok || (route_ok && in_cmd.func == MLC_FC_RESET_ALL)) begin
            next_cfg = MLC_CFG_DEFAULT;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cfg <= MLC_CFG_DEFAULT;
        end else begin
            o_cfg <= next_cfg;
        end
    end

    // ----------------------------------------------------------------
    // Maintenance mode
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_maint_mode     <= 1'b0;
            o_maint_func_act <= 1'b0;
        end else begin
            if (i_cpu_mclr || (deliver && in_cmd.func == MLC_FC_MAINT_CLR)) begin
                o_maint_mode <= 1'b0;
            end else if (deliver && in_cmd.func == MLC_FC_MAINT_SET) begin
                o_maint_mode <= 1'b1;
            end
            if (deliver && in_cmd.func == MLC_FC_MAINT_CLR) begin
                o_maint_func_act <= 1'b0;
            end else if (deliver && is_maint && in_cmd.func != MLC_FC_MAINT_SET) begin
                o_maint_func_act <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Error logger and disconnect
    // ----------------------------------------------------------------
    logic log_off;

    assign log_off = route_ok && mod_type == MLC_MOD_BSCAN && in_cmd.func == MLC_FC_LOG_OFF;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_logger_en  <= 1'b1;
            o_disconnect <= 1'b0;
            disc_sticky  <= 1'b0;
        end else begin
            o_disconnect <= log_off;
            if (log_off) begin
                o_logger_en <= 1'b0;
            end else if (route_ok && mod_type == MLC_MOD_BSCAN && in_cmd.func == MLC_FC_LOG_ON) begin
                o_logger_en <= 1'b1;
            end
            if (log_off) begin
                disc_sticky <= 1'b1;
            end else if (clr_disc) begin
                disc_sticky <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_issue(logic [7:0] f);
        route_ok && in_cmd.func == f;
    endsequence

    a_bcast_io_loops: assert property (o_strobe && last_cmd.loop == MLC_LOOP_BCAST && mod_type == MLC_MOD_IO
        |-> &o_loop_sel) else $error("broadcast missed a loop");
    a_bcast_std_loops: assert property (o_strobe && last_cmd.loop == MLC_LOOP_BCAST && mod_type != MLC_MOD_IO
        |-> o_loop_sel[MLC_NLOOP_STD-1:0] == '1 && o_loop_sel[NLOOP-1:MLC_NLOOP_STD] == '0)
        else $error("wrong broadcast width");
    a_single_loop: assert property (o_strobe && last_cmd.loop != MLC_LOOP_BCAST |-> $onehot0(o_loop_sel))
        else $error("single loop select not one-hot");
    a_univ_chip: assert property (deliver && |sel && in_cmd.chip_lo == MLC_CHIP_UNIV |=> &o_opt_accept)
        else $error("universal chip type not accepted");
    a_route_gate: assert property (issue && in_cmd.route != MLC_ROUTE_LC && i_sanity_ok
        |=> !o_strobe && $stable(o_cfg)) else $error("command taken with wrong route");
    a_cfg_sanity: assert property (!i_sanity_ok |=> o_cfg == MLC_CFG_DEFAULT)
        else $error("configuration not defaulted");
    a_io_path_set: assert property (s_issue(MLC_FC_PATH1_SET) ##0 mod_type == MLC_MOD_IO && i_sanity_ok
        |=> o_cfg.io_path[1]) else $error("path bit 1 not set");
    a_maint_reject: assert property (route_ok && is_maint && !o_maint_mode && in_cmd.func != MLC_FC_MAINT_SET
        && in_cmd.func != MLC_FC_MAINT_CLR |=> !o_strobe) else $error("maintenance function passed");
    a_maint_exit: assert property (s_issue(MLC_FC_MAINT_CLR) |=> !o_maint_mode && !o_maint_func_act)
        else $error("maintenance not cleared");
    a_mclr_exit: assert property (i_cpu_mclr |=> !o_maint_mode)
        else $error("master clear left maintenance mode");
    a_logger_off: assert property (s_issue(MLC_FC_LOG_OFF) ##0 mod_type == MLC_MOD_BSCAN
        |=> o_disconnect && !o_logger_en ##1 !o_disconnect) else $error("logger off sequence wrong");
endmodule

// ### mlc_loop_decode.sv
// Loop selection decoder: broadcast or a single loop
module mlc_loop_decode #(
    parameter int NLOOP_IO  = 32,
    parameter int NLOOP_STD = 16
) (
    input  wire logic [5:0]          i_loop,
    input  wire logic                i_io,
    output logic      [NLOOP_IO-1:0] o_sel
);
    import mlc_pkg::*;

    always_comb begin
        o_sel = '0;
        if (i_loop == MLC_LOOP_BCAST) begin
            for (int i = 0; i < NLOOP_IO; i++) begin
                o_sel[i] = i_io || (i < NLOOP_STD);
            end
        end else if (int'(i_loop) < (i_io ? NLOOP_IO : NLOOP_STD)) begin
            o_sel[i_loop[4:0]] = 1'b1;
        end
    end
endmodule

// ### mlc_node_model.sv
// Upstream node model: APB master that delivers routed command words
module mlc_node_model (
    input  wire logic        i_core_clk,
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic [7:0]       o_paddr,
    output logic [31:0]      o_pwdata,
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    import mlc_pkg::*;

    initial begin
        o_psel    = 1'b0;
        o_penable = 1'b0;
        o_pwrite  = 1'b0;
        o_paddr   = 8'hFF;
        o_pwdata  = 32'hFFFF_FFFF;
    end

    // ----------------------------------------------------------------
    // One transfer: setup, then access held until pready
    // ----------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge i_core_clk);
        o_psel   <= 1'b1;
        o_pwrite <= wr;
        o_paddr  <= a;
        o_pwdata <= d;
        @(posedge i_core_clk);
        o_penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
        end while (i_pready !== 1'b1);
        rd = i_prdata;
        err = i_pslverr;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
        o_paddr   <= ~a;
        o_pwdata  <= ~d;
    endtask

    // ----------------------------------------------------------------
    // Command word: upper word first, then the lower word carrying the route
    // ----------------------------------------------------------------
    task automatic cmd(input logic [4:0] r, input logic [5:0] l, input logic [4:0] h, lo,
                       input logic [7:0] f);
        mlc_cmd_s    c;
        logic [31:0] rd;
        logic        e;
        c = '{route: r, loop: l, chip_hi: h, chip_lo: lo, func: f};
        xfer(1'b1, MLC_OFF_CMD_HI, 32'h0000_0010, rd, e);
        xfer(1'b1, MLC_OFF_CMD_LO, {3'h0, c}, rd, e);
    endtask
endmodule

// ### mlc_pkg.sv
// Package: constants, field layouts and carrier types of the maintenance loop controller
package mlc_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] MLC_OFF_CMD_LO = 8'h00;
    localparam logic [7:0] MLC_OFF_CMD_HI = 8'h04;
    localparam logic [7:0] MLC_OFF_CTRL   = 8'h08;
    localparam logic [7:0] MLC_OFF_STAT   = 8'h0C;
    localparam logic [7:0] MLC_OFF_CFG    = 8'h10;

    // ----------------------------------------------------------------
    // Command word layout and special values
    // ----------------------------------------------------------------
    localparam int         MLC_CMD_W      = 29;
    localparam int         MLC_NLOOP_IO   = 32;
    localparam int         MLC_NLOOP_STD  = 16;
    localparam logic [4:0] MLC_ROUTE_LC   = 5'h18;
    localparam logic [5:0] MLC_LOOP_BCAST = 6'h3F;
    localparam logic [4:0] MLC_CHIP_UNIV  = 5'h1B;
    localparam logic [1:0] MLC_CLASS_MNT  = 2'h1;

    // ----------------------------------------------------------------
    // Function codes
    // ----------------------------------------------------------------
    localparam logic [7:0] MLC_FC_DETACH_ON   = 8'h00;
    localparam logic [7:0] MLC_FC_DETACH_OFF  = 8'h01;
    localparam logic [7:0] MLC_FC_PATH0_SET   = 8'h08;
    localparam logic [7:0] MLC_FC_PATH1_SET   = 8'h09;
    localparam logic [7:0] MLC_FC_PATH_CLR    = 8'h0A;
    localparam logic [7:0] MLC_FC_GRPMODE_SET = 8'h10;
    localparam logic [7:0] MLC_FC_GRPMODE_CLR = 8'h11;
    localparam logic [7:0] MLC_FC_MEMG0_SET   = 8'h12;
    localparam logic [7:0] MLC_FC_MEMG0_CLR   = 8'h13;
    localparam logic [7:0] MLC_FC_MEMG1_SET   = 8'h14;
    localparam logic [7:0] MLC_FC_MEMG1_CLR   = 8'h15;
    localparam logic [7:0] MLC_FC_IOG0_SET    = 8'h16;
    localparam logic [7:0] MLC_FC_IOG0_CLR    = 8'h17;
    localparam logic [7:0] MLC_FC_IOG1_SET    = 8'h18;
    localparam logic [7:0] MLC_FC_IOG1_CLR    = 8'h19;
    localparam logic [7:0] MLC_FC_POS_HW      = 8'h20;
    localparam logic [7:0] MLC_FC_POS_F1      = 8'h23;
    localparam logic [7:0] MLC_FC_MAINT100    = 8'h24;
    localparam logic [7:0] MLC_FC_DATA_EN     = 8'h25;
    localparam logic [7:0] MLC_FC_LOG_ON      = 8'h30;
    localparam logic [7:0] MLC_FC_LOG_OFF     = 8'h31;
    localparam logic [7:0] MLC_FC_RSAN_ON     = 8'h38;
    localparam logic [7:0] MLC_FC_RSAN_OFF    = 8'h39;
    localparam logic [7:0] MLC_FC_RESET_ALL   = 8'h3F;
    localparam logic [7:0] MLC_FC_MAINT_SET   = 8'h7E;
    localparam logic [7:0] MLC_FC_MAINT_CLR   = 8'h7F;

    // ----------------------------------------------------------------
    // Option chip codes fed by the per-option lines {upper, lower}
    // ----------------------------------------------------------------
    localparam int         MLC_NOPT = 6;
    localparam logic [9:0] MLC_OPT_CODE [MLC_NOPT] = '{
        10'h244, 10'h024, 10'h044, 10'h064, 10'h084, 10'h0A4};

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MLC_MOD_CPU    = 2'h0,
        MLC_MOD_IO     = 2'h1,
        MLC_MOD_SHARED = 2'h2,
        MLC_MOD_BSCAN  = 2'h3
    } mlc_mod_e;

    typedef struct packed {
        logic [4:0] route;
        logic [5:0] loop;
        logic [4:0] chip_hi;
        logic [4:0] chip_lo;
        logic [7:0] func;
    } mlc_cmd_s;

    typedef struct packed {
        logic       io_group_mode;
        logic [1:0] io_path;
        logic [1:0] io_mem_grp;
        logic [1:0] io_io_grp;
        logic [1:0] sr_pos;
        logic       sr_remote_sanity;
        logic       sr_auto_detach;
        logic       sr_data_en;
    } mlc_cfg_s;

    localparam mlc_cfg_s MLC_CFG_DEFAULT = '0;
    localparam logic [1:0] MLC_CTRL_RST  = 2'h0;

endpackage

// ### testbench.sv
// Self-checking testbench of the maintenance loop controller
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import mlc_pkg::*;

    typedef struct packed {logic [31:0] sel; logic [7:0] func; logic [5:0] opt;} mlc_tb_exp_s;
    logic        i_core_clk, i_rst, psel, penable, pwrite, pready, pslverr, sanity_ok, cpu_mclr;
    logic        strobe, maint, mact, log_en, disc, err;
    logic [7:0]  paddr, func;
    logic [31:0] pwdata, prdata, loop_sel, rd;
    logic [5:0]  opt;
    logic [15:0] lfsr_st = 16'h000E;
    logic [4:0]  v;
    mlc_cfg_s    cfg, exp_cfg;
    mlc_mod_e    mode;
    mlc_tb_exp_s q[$], e;
    int          n_mismatch = 0, cmp_count = 0, n_disc = 0;
    logic [7:0]  io_codes [18] = '{8'h08, 8'h09, 8'h0A, 8'h09, 8'h10, 8'h12, 8'h14, 8'h16, 8'h18,
                                   8'h05, 8'h11, 8'h13, 8'h15, 8'h17, 8'h19, 8'h16, 8'h12, 8'h3F};
    logic [7:0]  sh_codes [12] = '{8'h00, 8'h21, 8'h23, 8'h22, 8'h38, 8'h25, 8'h24, 8'h25,
                                   8'h01, 8'h39, 8'h38, 8'h3F};

    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end

    mlc_loop_ctrl DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_sanity_ok(sanity_ok), .i_cpu_mclr(cpu_mclr), .o_strobe(strobe),
        .o_loop_sel(loop_sel), .o_func(func), .o_opt_accept(opt), .o_cfg(cfg), .o_maint_mode(maint),
        .o_maint_func_act(mact), .o_logger_en(log_en), .o_disconnect(disc));

    mlc_node_model node (.i_core_clk(i_core_clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
        .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));

    task automatic check(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        check("queue", q.size(), 0);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // ----------------------------------------------------------------
    // Expected configuration after one delivered code
    // ----------------------------------------------------------------
    function automatic void upd(input logic [7:0] f);
        v = {exp_cfg.io_io_grp, exp_cfg.io_mem_grp, exp_cfg.io_group_mode};
        if (mode == MLC_MOD_IO && f >= 8'h10 && f <= 8'h19) v[(f - 8'h10) >> 1] = ~f[0];
        {exp_cfg.io_io_grp, exp_cfg.io_mem_grp, exp_cfg.io_group_mode} = v;
        if (mode == MLC_MOD_IO && (f == 8'h08 || f == 8'h09)) exp_cfg.io_path[f[0]] = 1'b1;
        if (mode == MLC_MOD_IO && f == 8'h0A) exp_cfg.io_path = 2'h0;
        if (mode == MLC_MOD_SHARED && f[7:1] == 7'h00) exp_cfg.sr_auto_detach = ~f[0];
        if (mode == MLC_MOD_SHARED && f[7:2] == 6'h08) exp_cfg.sr_pos = f[1:0];
        if (mode == MLC_MOD_SHARED && f[7:1] == 7'h12) exp_cfg.sr_data_en = f[0];
        if (mode == MLC_MOD_SHARED && f[7:1] == 7'h1C) exp_cfg.sr_remote_sanity = ~f[0];
        if (f == MLC_FC_RESET_ALL || sanity_ok !== 1'b1) exp_cfg = MLC_CFG_DEFAULT;
    endfunction

    task automatic setmod(input mlc_mod_e m);
        mode = m;
        node.xfer(1'b1, MLC_OFF_CTRL, {30'h0, m}, rd, err);
    endtask

    task automatic send(input logic [5:0] l, input logic [4:0] h, lo, input logic [7:0] f,
                        input logic st, input logic [31:0] es, input logic [5:0] eo);
        if (st) q.push_back('{es, f, eo});
        upd(f);
        node.cmd(MLC_ROUTE_LC, l, h, lo, f);
        repeat (2) @(posedge i_core_clk);
        #1;
        check("cfg", 32'(cfg), 32'(exp_cfg));
    endtask

    always @(posedge i_core_clk) begin
        if (disc === 1'b1) n_disc++;
        if (strobe === 1'b1 && q.size() == 0) check("strobe", 1, 0);
        if (strobe === 1'b1 && q.size() != 0) begin
            e = q.pop_front();
            check("loop_sel", loop_sel, e.sel);
            check("func", func, e.func);
            check("opt", opt, e.opt);
        end
    end

    initial begin
        repeat (20000) @(posedge i_core_clk);
        n_mismatch++;
        final_report();
    end

    initial begin
        i_rst = 1'b1;
        sanity_ok = 1'b1;
        cpu_mclr = 1'b0;
        exp_cfg = MLC_CFG_DEFAULT;
        mode = MLC_MOD_CPU;
        repeat (3) @(posedge i_core_clk);
        i_rst <= 1'b0;
        #1;
        check("cfg_rst", 32'(cfg), 0);
        check("log_rst", log_en, 1);
        setmod(MLC_MOD_IO);
        send(6'h3F, 5'h00, MLC_CHIP_UNIV, 8'h80, 1, 32'hFFFF_FFFF, 6'h3F);
        send(6'd2, 5'h01, 5'h04, 8'h81, 1, 32'h4, 6'h02);
        send(6'd31, 5'h12, 5'h04, 8'h82, 1, 32'h8000_0000, 6'h01);
        node.cmd(5'h17, 6'h00, 5'h01, 5'h01, MLC_FC_PATH0_SET);
        send(6'd0, 5'h01, 5'h01, 8'h05, 1, 32'h1, 6'h00);
        repeat (8) begin
            lfsr_st = lfsr(lfsr_st);
            send({1'b0, lfsr_st[4:0]}, 5'h12, 5'h04, {1'b1, lfsr_st[14:8]}, 1, 32'h1 << lfsr_st[4:0], 6'h01);
        end
        foreach (io_codes[i]) send(6'd0, 5'h01, 5'h01, io_codes[i], 1, 32'h1, 6'h00);
        setmod(MLC_MOD_SHARED);
        foreach (sh_codes[i]) send(6'd0, 5'h01, 5'h01, sh_codes[i], 1, 32'h1, 6'h00);
        send(6'd0, 5'h01, 5'h01, 8'h25, 1, 32'h1, 6'h00);
        setmod(MLC_MOD_CPU);
        send(6'h3F, 5'h01, 5'h01, 8'h83, 1, 32'h0000_FFFF, 6'h00);
        send(6'd0, 5'h01, 5'h01, 8'h41, 0, 0, 0);
        check("maint_off", maint, 0);
        send(6'd0, 5'h01, 5'h01, MLC_FC_MAINT_SET, 1, 32'h1, 6'h00);
        check("maint_on", {maint, mact}, 2'b10);
        send(6'd0, 5'h01, 5'h01, 8'h41, 1, 32'h1, 6'h00);
        check("func_act", mact, 1);
        send(6'd0, 5'h01, 5'h01, MLC_FC_MAINT_CLR, 1, 32'h1, 6'h00);
        check("maint_clr", {maint, mact}, 2'b00);
        send(6'd0, 5'h01, 5'h01, 8'h42, 0, 0, 0);
        send(6'd0, 5'h01, 5'h01, MLC_FC_MAINT_SET, 1, 32'h1, 6'h00);
        @(posedge i_core_clk) cpu_mclr <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        #1;
        check("maint_mclr", maint, 0);
        send(6'd0, 5'h01, 5'h01, MLC_FC_MAINT_SET, 1, 32'h1, 6'h00);
        check("maint_mclr_win", maint, 0);
        @(posedge i_core_clk) cpu_mclr <= 1'b0;
        setmod(MLC_MOD_IO);
        send(6'd0, 5'h01, 5'h01, 8'h08, 1, 32'h1, 6'h00);
        node.xfer(1'b0, MLC_OFF_CFG, 32'h0, rd, err);
        check("cfg_reg", rd, 32'(exp_cfg));
        @(posedge i_core_clk) sanity_ok <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        exp_cfg = MLC_CFG_DEFAULT;
        send(6'd0, 5'h01, 5'h01, 8'h09, 1, 32'h1, 6'h00);
        @(posedge i_core_clk) sanity_ok <= 1'b1;
        setmod(MLC_MOD_BSCAN);
        send(6'h3F, 5'h01, 5'h01, MLC_FC_LOG_OFF, 1, 32'h0000_FFFF, 6'h00);
        check("logger_off", log_en, 0);
        check("disc_pulse", n_disc, 1);
        node.xfer(1'b0, MLC_OFF_STAT, 32'h0, rd, err);
        check("stat", rd[3:2], 2'b10);
        node.xfer(1'b1, MLC_OFF_STAT, 32'h8, rd, err);
        node.xfer(1'b0, MLC_OFF_STAT, 32'h0, rd, err);
        check("stat_clr", rd[3:2], 2'b00);
        send(6'd0, 5'h01, 5'h01, MLC_FC_LOG_ON, 1, 32'h1, 6'h00);
        check("logger_on", log_en, 1);
        node.xfer(1'b0, MLC_OFF_CMD_LO, 32'h0, rd, err);
        check("cmd_lo", rd, {3'h0, MLC_ROUTE_LC, 6'h00, 5'h01, 5'h01, MLC_FC_LOG_ON});
        check("cmd_err", err, 0);
        node.xfer(1'b0, 8'h20, 32'h0, rd, err);
        check("unmapped_err", err, 1);
        check("unmapped_rd", rd, 0);
        final_report();
    end
endmodule
